/* File: sim/siw_far_model.sv */
/*
 * siw_far_model: split engine and translated device answering issue pulses.
 * Assumes the bench sets bytes, result flags and answer delay before a tick.
 */
`timescale 1ns/1ns
module siw_far_model (
   input  wire logic       pclk,          // bus clock
   input  wire logic       presetn,       // async reset, active low
   input  wire logic       ss_issue,      // start split pulse
   input  wire logic       cs_issue,      // complete split pulse
   input  wire logic [2:0] issue_uframe,  // microframe of pulse
   input  wire logic [7:0] cfg_bytes,     // bytes to report
   input  wire logic [2:0] cfg_err,       // underrun, babble, error flags
   input  wire logic [3:0] cfg_delay,     // cycles before report
   output logic            res_valid,     // report pulse
   output logic      [2:0] res_uframe,    // microframe of report
   output logic            res_split,     // 0 start, 1 complete
   output logic      [7:0] res_bytes,     // bytes received
   output logic            res_txerr,     // transaction error
   output logic            res_babble,    // babble
   output logic            res_underrun   // underrun
);
   logic       pend_ff;                   // report owed
   logic [3:0] wait_ff;                   // cycles left before report
   logic       split_ff;                  // kind of owed report
   logic [2:0] uf_ff;                     // microframe of owed report
   logic [7:0] bytes_ff;                  // latched byte count
   logic [2:0] err_ff;                    // latched flags

   // outside a report the lines show junk, never the last value
   assign res_bytes = res_valid ? bytes_ff : ~bytes_ff;
   assign {res_underrun, res_babble, res_txerr} = res_valid ? err_ff : ~err_ff;
   assign res_uframe = res_valid ? uf_ff : ~uf_ff;
   assign res_split = res_valid ? split_ff : ~split_ff;

   // one report per issue cycle, complete over start, a new pulse replacing an owed one, after a prompt or slow delay
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_ff   <= 1'b0;
         wait_ff   <= 4'h0;
         split_ff  <= 1'b0;
         uf_ff     <= 3'h0;
         bytes_ff  <= 8'h00;
         err_ff    <= 3'h0;
         res_valid <= 1'b0;
      end else begin
         res_valid <= 1'b0;
         if (ss_issue || cs_issue) begin
            pend_ff  <= 1'b1;
            wait_ff  <= cfg_delay;
            split_ff <= cs_issue;
            uf_ff    <= issue_uframe;
         end else if (pend_ff && wait_ff != 4'h0) begin
            wait_ff <= wait_ff - 4'h1;
         end else if (pend_ff) begin
            pend_ff   <= 1'b0;
            res_valid <= 1'b1;
            bytes_ff  <= cfg_bytes;
            err_ff    <= cfg_err;
         end
      end
   end
endmodule

/* File: sim/siw_properties.sv */
/*
 * siw_properties: bus and split issue checks for siw_writeback.
 * Assumes it is bound to siw_writeback and watches its ports only.
 */
`timescale 1ns/1ns
module siw_properties (
   input wire logic        pclk,          // bus clock
   input wire logic        presetn,       // async reset, active low
   input wire logic        psel,          // apb select
   input wire logic        penable,       // apb access phase
   input wire logic        pwrite,        // apb direction
   input wire logic [7:0]  paddr,         // apb byte address
   input wire logic [31:0] prdata,        // apb read data
   input wire logic        pready,        // apb ready
   input wire logic        pslverr,       // apb error
   input wire logic        uframe_tick,   // microframe start
   input wire logic [2:0]  uframe_num,    // microframe number
   input wire logic        frame_match,   // frame number match
   input wire logic        ss_issue,      // start split pulse
   input wire logic        cs_issue,      // complete split pulse
   input wire logic [2:0]  issue_uframe   // microframe of pulse
);
   // one clock domain, one reset
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_ready_in_access: assert property (psel && !penable |=> pready && penable)
      else $error("ready missing in access cycle");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_ready_has_setup: assert property (pready |-> $past(psel) && !$past(penable))
      else $error("ready without setup");
   a_unmapped_error: assert property (pready && paddr > 8'h1C |-> pslverr)
      else $error("unmapped access not refused");
   a_unmapped_zero: assert property (pready && !pwrite && paddr > 8'h1C |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   a_write_data_quiet: assert property (pready && pwrite |-> prdata == 32'h0)
      else $error("read data driven on write");
   a_word7_reserved: assert property (
      pready && !pwrite && paddr == 8'h10 |-> prdata[31:8] == 24'h0)
      else $error("reserved bits of word seven set");
   a_start_cause: assert property (
      ss_issue |-> $past(uframe_tick) && $past(frame_match))
      else $error("start split without matched tick");
   a_complete_cause: assert property (cs_issue |-> $past(uframe_tick))
      else $error("complete split without tick");
   a_issue_slot: assert property (
      ss_issue || cs_issue |-> issue_uframe == $past(uframe_num))
      else $error("issue in wrong microframe");
endmodule

bind siw_writeback siw_properties u_siw_properties (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .uframe_tick(uframe_tick), .uframe_num(uframe_num), .frame_match(frame_match),
   .ss_issue(ss_issue), .cs_issue(cs_issue), .issue_uframe(issue_uframe)
);

/* File: sim/tb_siw_writeback.sv */
/*
 * tb_siw_writeback: register and split result tests of siw_writeback.
 * Assumes the far model answers every issue pulse within sixteen cycles.
 */
`timescale 1ns/1ns
module tb_siw_writeback;
   logic        pclk = 1'b0;              // 10 MHz bus clock
   logic        presetn = 1'b0;           // reset, active low
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;            // bus address
   logic [31:0] pwdata = 32'h0, prdata;   // bus data
   logic        pready, pslverr, irq;     // bus answer and interrupt
   logic        uframe_tick = 1'b0, frame_match = 1'b0;
   logic [2:0]  uframe_num = 3'h0;        // microframe of tick
   logic [7:0]  cfg_bytes = 8'h00;        // bytes the model reports
   logic [2:0]  cfg_err = 3'h0;           // flags the model reports
   logic [3:0]  cfg_delay = 4'h0;         // model answer delay
   logic        res_valid, res_split, res_txerr, res_babble, res_underrun;
   logic [2:0]  res_uframe, issue_uframe; // report and issue slots
   logic [7:0]  res_bytes;                // reported count
   logic        ss_issue, cs_issue;       // issue pulses
   logic [31:0] rd, exp4;                 // read data, expected word4
   logic        er, seen;                 // error flag, issue seen
   logic [2:0]  seen_uf;                  // slot of seen issue
   int          num_errors = 0, checked = 0, cycles = 0;

   always #50 pclk = ~pclk;

   siw_writeback u_siw_writeback (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .uframe_tick(uframe_tick),
      .uframe_num(uframe_num), .frame_match(frame_match), .res_valid(res_valid),
      .res_uframe(res_uframe), .res_split(res_split), .res_bytes(res_bytes),
      .res_txerr(res_txerr), .res_babble(res_babble), .res_underrun(res_underrun),
      .ss_issue(ss_issue), .cs_issue(cs_issue), .issue_uframe(issue_uframe), .irq(irq));
   siw_far_model u_siw_far_model (.pclk(pclk), .presetn(presetn), .ss_issue(ss_issue),
      .cs_issue(cs_issue), .issue_uframe(issue_uframe), .cfg_bytes(cfg_bytes),
      .cfg_err(cfg_err), .cfg_delay(cfg_delay), .res_valid(res_valid),
      .res_uframe(res_uframe), .res_split(res_split), .res_bytes(res_bytes),
      .res_txerr(res_txerr), .res_babble(res_babble), .res_underrun(res_underrun));

   // compare a bus word
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // compare a single flag
   task automatic chk_bit(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // one apb transfer, result left in rd and er
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // microframe tick, then watch sixteen cycles for an issue pulse
   task automatic tick(input logic [2:0] u, input logic m, input logic [7:0] b,
                       input logic [2:0] e, input logic exp_iss);
      seen = 1'b0;
      @(posedge pclk);
      uframe_tick <= 1'b1;
      uframe_num  <= u;
      frame_match <= m;
      cfg_bytes   <= b;
      cfg_err     <= e;
      cfg_delay   <= u[0] ? 4'h5 : 4'h0;
      @(posedge pclk);
      uframe_tick <= 1'b0;
      repeat (16) begin
         @(posedge pclk);
         if ((ss_issue | cs_issue) === 1'b1) begin
            seen = 1'b1;
            seen_uf = issue_uframe;
         end
      end
      chk_bit(seen, exp_iss);
      if (exp_iss) chk_word({29'h0, seen_uf}, {29'h0, u});
   endtask

   // verdict and end of run
   task automatic give_verdict;
      if (num_errors == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // hang guard
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         give_verdict();
      end
   end

   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      // reset values of every register, then the unmapped place
      for (int a = 0; a < 32; a += 4) begin
         apb(1'b0, 8'(a), 32'h0);
         chk_word(rd, 32'h0);
      end
      apb(1'b1, 8'h20, 32'hFFFF_FFFF);
      chk_bit(er, 1'b1);
      apb(1'b0, 8'h20, 32'h0);
      chk_bit(er, 1'b1);
      // IN transfer: start in slot 0, complete in slot 2
      apb(1'b1, 8'h00, 32'h3);
      apb(1'b1, 8'h04, 32'h01);
      apb(1'b1, 8'h08, 32'h04);
      tick(3'h0, 1'b1, 8'h5A, 3'h0, 1'b1);
      tick(3'h2, 1'b1, 8'hC3, 3'h0, 1'b1);
      apb(1'b0, 8'h08, 32'h0);
      chk_word(rd, 32'h0000_5A00);
      apb(1'b0, 8'h04, 32'h0);
      chk_word(rd, 32'h0);
      chk_bit(irq, 1'b0);
      apb(1'b1, 8'h1C, 32'h2);
      repeat (2) @(posedge pclk);
      chk_bit(irq, 1'b1);
      apb(1'b0, 8'h18, 32'h0);
      chk_word(rd, 32'h3);
      repeat (2) @(posedge pclk);
      chk_bit(irq, 1'b0);
      // OUT transfer in all eight slots, flags vary per slot
      apb(1'b1, 8'h00, 32'h1);
      apb(1'b1, 8'h04, 32'hFF);
      exp4 = 32'h0;
      for (int u = 0; u < 8; u++) begin
         tick(3'(u), 1'b1, 8'(8'h10 + u), 3'(u), 1'b1);
         exp4 |= 32'(u & 5) << (8 + 3 * u);
      end
      apb(1'b0, 8'h04, 32'h0);
      chk_word(rd, exp4);
      apb(1'b0, 8'h08, 32'h0);
      chk_word(rd, 32'h1211_1000);
      apb(1'b0, 8'h0C, 32'h0);
      chk_word(rd, 32'h1615_1413);
      apb(1'b0, 8'h10, 32'h0);
      chk_word(rd, 32'h0000_0017);
      apb(1'b0, 8'h14, 32'h0);
      chk_word(rd, 32'h1);
      // IN again: unmatched frame, then babble with all flags
      apb(1'b1, 8'h00, 32'h3);
      apb(1'b1, 8'h04, 32'h0A);
      tick(3'h3, 1'b0, 8'h99, 3'h1, 1'b0);
      tick(3'h1, 1'b1, 8'h77, 3'h7, 1'b1);
      exp4 = (exp4 & ~(32'h7 << 11)) | (32'h3 << 11) | 32'h8;
      apb(1'b0, 8'h04, 32'h0);
      chk_word(rd, exp4);
      apb(1'b0, 8'h08, 32'h0);
      chk_word(rd, 32'h1277_1000);
      apb(1'b0, 8'h0C, 32'h0);
      chk_word(rd, 32'h1615_1413);
      apb(1'b0, 8'h14, 32'h0);
      chk_word(rd, 32'h3);
      give_verdict();
   end
endmodule

/* File: src/siw_pkg.sv */
/*
 * siw_pkg: constants and types of the interrupt split result writeback block.
 * Assumes a single 10 MHz APB clock; clock rate, offsets, field positions and reset constants live here.
 */
package siw_pkg;

   // clock rate and microframe count
   localparam int unsigned CLK_HZ          = 10_000_000;
   localparam int unsigned UFRAMES         = 8;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL         = 8'h00;
   localparam logic [7:0] OFS_WORD4        = 8'h04;
   localparam logic [7:0] OFS_WORD5        = 8'h08;
   localparam logic [7:0] OFS_WORD6        = 8'h0C;
   localparam logic [7:0] OFS_WORD7        = 8'h10;
   localparam logic [7:0] OFS_SUMMARY      = 8'h14;
   localparam logic [7:0] OFS_IRQ_STS      = 8'h18;
   localparam logic [7:0] OFS_IRQ_MSK      = 8'h1C;

   // control register fields
   localparam int unsigned CTRL_EN_BIT     = 0;
   localparam int unsigned CTRL_IN_BIT     = 1;

   // word4 layout: results from bit 8 upward, three bits each
   localparam int unsigned W4_RES_LSB      = 8;
   localparam int unsigned RES_W           = 3;
   // word5 upper half: counts 0..2 from bit 8, cs mask in bits 7..0
   localparam int unsigned W5_CNT_LSB      = 8;
   localparam int unsigned CNT_W           = 8;

   // result code bits
   localparam int unsigned RES_TXERR_BIT   = 0;
   localparam int unsigned RES_BABBLE_BIT  = 1;
   localparam int unsigned RES_UNDERRUN_BIT = 2;

   // summary register bits
   localparam int unsigned SUM_TXERR_BIT   = 0;
   localparam int unsigned SUM_BABBLE_BIT  = 1;

   // interrupt status bits
   localparam int unsigned IRQ_W           = 3;
   localparam int unsigned IRQ_SS_BIT      = 0;
   localparam int unsigned IRQ_CS_BIT      = 1;
   localparam int unsigned IRQ_ERR_BIT     = 2;

   // reset values
   localparam logic [7:0]  RST_MASK        = 8'h00;
   localparam logic [2:0]  RST_RESULT      = 3'h0;
   localparam logic [7:0]  RST_COUNT       = 8'h00;
   localparam logic [31:0] RST_RDATA       = 32'h0000_0000;

   // split kind of a reported result
   typedef enum logic {
      SIW_SPLIT_START    = 1'b0,
      SIW_SPLIT_COMPLETE = 1'b1
   } siw_split_t;

   // state of one microframe slot
   typedef struct packed {
      logic [7:0] count;                  // bytes received
      logic [2:0] result;                 // result code
   } siw_slot_t;

   // state of the main block
   typedef struct packed {
      logic        enable;                // engine runs
      logic        dir_in;                // transfer is IN
      logic [7:0]  ss_mask;               // start split mask
      logic [7:0]  cs_mask;               // complete split mask
      logic [7:0]  armed;                 // frame matched uframes with start split
      logic [2:0]  irq_sts;               // sticky events
      logic [2:0]  irq_msk;               // event enables
      logic [2:0]  rd_sts;                // status returned by pending read
      logic [31:0] prdata;                // read data
      logic        pready;                // access answer
      logic        pslverr;               // unmapped access
      logic        ss_go;                 // start split issue pulse
      logic        cs_go;                 // complete split issue pulse
      logic [2:0]  go_uframe;             // microframe of issue pulse
      logic        irq;                   // interrupt level
   } siw_state_t;

endpackage

/* File: src/siw_slot.sv */
/*
 * siw_slot: one microframe's received count and result code.
 * Assumes load strobes come from logic on the same clock.
 */
`timescale 1ns/1ns
module siw_slot (
   input  wire logic       pclk,          // system clock
   input  wire logic       presetn,       // async reset, active low
   input  wire logic       load_count,    // replace count
   input  wire logic       load_result,   // replace result code
   input  wire logic [7:0] count_in,      // new byte count
   input  wire logic [2:0] result_in,     // new result code
   output logic      [7:0] count,         // held byte count
   output logic      [2:0] result         // held result code
);

   siw_pkg::siw_slot_t slot_ff;           // registered state
   siw_pkg::siw_slot_t nxt_slot;          // next state

   // each new count overwrites the old one
   always_comb begin
      nxt_slot = slot_ff;
      if (load_count) begin
         nxt_slot.count = count_in;
      end
      if (load_result) begin
         nxt_slot.result = result_in;
      end
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slot_ff.count  <= siw_pkg::RST_COUNT;
         slot_ff.result <= siw_pkg::RST_RESULT;
      end else begin
         slot_ff <= nxt_slot;
      end
   end

   assign count  = slot_ff.count;
   assign result = slot_ff.result;

endmodule

/* File: src/siw_writeback.sv */
/*
 * siw_writeback: split transaction result writeback for interrupt transfers,
 * with an APB register slave mirroring descriptor words 4 to 7.
 * Assumes the microframe tick and result reports come from the split engine
 * on pclk, so they need no synchroniser.
 */
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ns
module siw_writeback (
   // clock and reset
   input  wire logic        pclk,         // apb clock, 10 MHz
   input  wire logic        presetn,      // async reset, active low

   // apb register slave
   input  wire logic        psel,         // apb select
   input  wire logic        penable,      // apb access phase
   input  wire logic        pwrite,       // apb direction
   input  wire logic [7:0]  paddr,        // apb byte address
   input  wire logic [31:0] pwdata,       // apb write data
   output logic      [31:0] prdata,       // apb read data
   output logic             pready,       // apb ready
   output logic             pslverr,      // apb error

   // microframe timing from the split engine
   input  wire logic        uframe_tick,  // start of a microframe
   input  wire logic [2:0]  uframe_num,   // microframe number of tick
   input  wire logic        frame_match,  // frame number matches polling

   // result report of a finished split
   input  wire logic        res_valid,    // split result report
   input  wire logic [2:0]  res_uframe,   // microframe of report
   input  wire logic        res_split,    // 0 start, 1 complete split
   input  wire logic [7:0]  res_bytes,    // bytes received
   input  wire logic        res_txerr,    // transaction error seen
   input  wire logic        res_babble,   // babble seen
   input  wire logic        res_underrun, // underrun seen

   // split issue requests and interrupt
   output logic             ss_issue,     // issue start split pulse
   output logic             cs_issue,     // issue complete split pulse
   output logic      [2:0]  issue_uframe, // microframe of issue pulse
   output logic             irq           // interrupt level
);

   siw_pkg::siw_state_t st_ff;            // registered state
   siw_pkg::siw_state_t nxt_st;           // next state

   // slot contents as seen by the readback
   logic [7:0] cnt   [siw_pkg::UFRAMES];  // slot counts
   logic [2:0] res   [siw_pkg::UFRAMES];  // slot result codes
   logic [7:0] ld_cnt;                    // count load strobes
   logic [7:0] ld_res;                    // result load strobes
   logic [2:0] res_code;                  // code to write back

   // readback views
   logic       sum_txerr;                 // any transaction error
   logic       sum_babble;                // any babble
   logic [31:0] word4;                    // word4 lower half view
   logic [31:0] word5;                    // word5 upper half view
   logic [31:0] word6;                    // word6 lower half view
   logic [31:0] word7;                    // word7 upper half view

   // one hot of a microframe number
   function automatic logic [7:0] uf_bit(input logic [2:0] n);
      uf_bit = 8'h01 << n;
   endfunction

   // apb setup phase decode
   function automatic logic is_setup(input logic sel, input logic en);
      is_setup = sel & ~en;
   endfunction

   // result code of a report, direction gated
   always_comb begin
      res_code = 3'h0;
      res_code[siw_pkg::RES_TXERR_BIT]    = res_txerr;
      res_code[siw_pkg::RES_BABBLE_BIT]   = res_babble & st_ff.dir_in;
      res_code[siw_pkg::RES_UNDERRUN_BIT] = res_underrun & ~st_ff.dir_in;
   end

   // per microframe slots
   // result code written on every report, the count
   // only when the slot was armed at its tick
   genvar g;
   generate
      for (g = 0; g < siw_pkg::UFRAMES; g++) begin : g_slot
         // count replaced only for armed, frame matched microframes
         assign ld_cnt[g] = res_valid && (res_uframe == 3'(g)) && st_ff.armed[g];
         assign ld_res[g] = res_valid && (res_uframe == 3'(g));

         siw_slot u_slot (
            .pclk        (pclk),
            .presetn     (presetn),
            .load_count  (ld_cnt[g]),
            .load_result (ld_res[g]),
            .count_in    (res_bytes),
            .result_in   (res_code),
            .count       (cnt[g]),
            .result      (res[g])
         );
      end
   endgenerate

   // summary flags and descriptor word views
   always_comb begin
      sum_txerr  = 1'b0;
      sum_babble = 1'b0;
      word4      = 32'h0000_0000;
      for (int i = 0; i < siw_pkg::UFRAMES; i++) begin
         sum_txerr  = sum_txerr | res[i][siw_pkg::RES_TXERR_BIT];
         sum_babble = sum_babble | res[i][siw_pkg::RES_BABBLE_BIT];
         // uframe 0 at bits 10..8 up to uframe 7 at bits 31..29
         word4[siw_pkg::W4_RES_LSB + siw_pkg::RES_W*i +: siw_pkg::RES_W] = res[i];
      end

      // start split mask in the low byte
      word4[7:0] = st_ff.ss_mask;

      // counts 2, 1, 0 at bits 63..40, cs mask at 39..32
      word5 = {cnt[2], cnt[1], cnt[0], st_ff.cs_mask};

      // counts 6, 5, 4, 3 at bits 31..0
      word6 = {cnt[6], cnt[5], cnt[4], cnt[3]};

      // count 7 at bits 39..32, bits 63..40 reserved as zero
      word7 = {24'h00_0000, cnt[7]};
   end

   // next state: split scheduling, mask clearing, apb slave, interrupts
   always_comb begin
      logic [7:0] uf_hot;                 // tick microframe one hot
      logic [7:0] res_hot;                // report microframe one hot
      logic [7:0] ss_clr;                 // start split bits done
      logic [7:0] cs_clr;                 // complete split bits done
      logic [7:0] ss_set;                 // software sets
      logic [7:0] cs_set;                 // software sets
      logic [2:0] ev;                     // events this cycle
      logic       wr_done;                // write completes
      logic       rd_done;                // read completes
      logic       hit;                    // mapped address

      // one hots decoded from the microframe numbers, other locals start cleared each pass
      uf_hot  = uf_bit(uframe_num);
      res_hot = uf_bit(res_uframe);
      ss_clr  = 8'h00;
      cs_clr  = 8'h00;
      ss_set  = 8'h00;
      cs_set  = 8'h00;
      ev      = 3'h0;
      hit     = 1'b0;
      nxt_st  = st_ff;
      // pulses and bus answer last one cycle
      nxt_st.ss_go   = 1'b0;
      nxt_st.cs_go   = 1'b0;
      nxt_st.pready  = 1'b0;
      nxt_st.pslverr = 1'b0;
      // access phase ends at this edge
      wr_done = psel & penable & st_ff.pready & pwrite;
      rd_done = psel & penable & st_ff.pready & ~pwrite;

      // microframe start: issue the splits its masks select
      if (uframe_tick && st_ff.enable) begin
         if (frame_match && |(st_ff.ss_mask & uf_hot)) begin
            nxt_st.ss_go = 1'b1;
            nxt_st.armed = st_ff.armed | uf_hot;
            ev[siw_pkg::IRQ_SS_BIT] = 1'b1;
         end else begin
            nxt_st.armed = st_ff.armed & ~uf_hot; // stale arming dropped
         end

         // complete splits only for IN transfers
         if (st_ff.dir_in && |(st_ff.cs_mask & uf_hot)) begin
            nxt_st.cs_go = 1'b1;
         end
         // slot of any pulse raised here
         nxt_st.go_uframe = uframe_num;
      end

      // result report: clear the processed mask bit
      if (res_valid) begin
         if (res_split == siw_pkg::SIW_SPLIT_START) begin
            ss_clr = res_hot;
         end else begin
            cs_clr = res_hot;
            ev[siw_pkg::IRQ_CS_BIT] = 1'b1;
         end
         // any set result bit is an event
         ev[siw_pkg::IRQ_ERR_BIT] = |res_code;
      end

      // apb setup: answer in the following access cycle
      if (is_setup(psel, penable)) begin
         nxt_st.pready = 1'b1;
         nxt_st.prdata = siw_pkg::RST_RDATA;
         nxt_st.rd_sts = 3'h0;
         hit = 1'b1;
         case (paddr)
            siw_pkg::OFS_CTRL: begin
               nxt_st.prdata[siw_pkg::CTRL_EN_BIT] = st_ff.enable;
               nxt_st.prdata[siw_pkg::CTRL_IN_BIT] = st_ff.dir_in;
            end
            siw_pkg::OFS_WORD4:   nxt_st.prdata = word4;
            siw_pkg::OFS_WORD5:   nxt_st.prdata = word5;
            siw_pkg::OFS_WORD6:   nxt_st.prdata = word6;
            siw_pkg::OFS_WORD7:   nxt_st.prdata = word7;

            siw_pkg::OFS_SUMMARY: begin
               nxt_st.prdata[siw_pkg::SUM_TXERR_BIT]  = sum_txerr;
               nxt_st.prdata[siw_pkg::SUM_BABBLE_BIT] = sum_babble;
            end

            siw_pkg::OFS_IRQ_STS: begin
               nxt_st.prdata[siw_pkg::IRQ_W-1:0] = st_ff.irq_sts;
               // only bits actually returned are cleared later
               nxt_st.rd_sts = pwrite ? 3'h0 : st_ff.irq_sts;
            end
            siw_pkg::OFS_IRQ_MSK: nxt_st.prdata[siw_pkg::IRQ_W-1:0] = st_ff.irq_msk;
            default: begin
               hit = 1'b0;
            end
         endcase
         // unmapped places answer with an error
         nxt_st.pslverr = ~hit;
         // a write returns zero read data
         if (pwrite) begin
            nxt_st.prdata = siw_pkg::RST_RDATA;
         end
      end

      // apb write completion
      if (wr_done && !st_ff.pslverr) begin
         case (paddr)
            siw_pkg::OFS_CTRL: begin
               nxt_st.enable = pwdata[siw_pkg::CTRL_EN_BIT];
               nxt_st.dir_in = pwdata[siw_pkg::CTRL_IN_BIT];
            end

            // writing one sets a mask bit, zero leaves it
            siw_pkg::OFS_WORD4: ss_set = pwdata[7:0];
            siw_pkg::OFS_WORD5: cs_set = pwdata[7:0];
            siw_pkg::OFS_IRQ_MSK: nxt_st.irq_msk = pwdata[siw_pkg::IRQ_W-1:0];
            default: begin
               ss_set = 8'h00;
            end
         endcase
      end

      // software set wins over hardware clear
      nxt_st.ss_mask = (st_ff.ss_mask & ~ss_clr) | ss_set;
      nxt_st.cs_mask = (st_ff.cs_mask & ~cs_clr) | cs_set;

      // read clear of returned status bits; new events win
      if (rd_done && !st_ff.pslverr) begin
         nxt_st.irq_sts = (st_ff.irq_sts & ~st_ff.rd_sts) | ev;
         nxt_st.rd_sts  = 3'h0;
      end else begin
         nxt_st.irq_sts = st_ff.irq_sts | ev;
      end

      // interrupt level from unmasked sticky bits
      nxt_st.irq = |(nxt_st.irq_sts & nxt_st.irq_msk);
   end

   // state register
   // reset acts without a clock edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff.enable    <= 1'b0;
         st_ff.dir_in    <= 1'b0;

         st_ff.ss_mask   <= siw_pkg::RST_MASK;
         st_ff.cs_mask   <= siw_pkg::RST_MASK;

         st_ff.armed     <= 8'h00;

         st_ff.irq_sts   <= 3'h0;
         st_ff.irq_msk   <= 3'h0;
         st_ff.rd_sts    <= 3'h0;

         st_ff.prdata    <= siw_pkg::RST_RDATA;
         st_ff.pready    <= 1'b0;
         st_ff.pslverr   <= 1'b0;

         st_ff.ss_go     <= 1'b0;
         st_ff.cs_go     <= 1'b0;
         st_ff.go_uframe <= 3'h0;

         st_ff.irq       <= 1'b0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // outputs straight from flops
   // every port below is a plain register
   assign prdata       = st_ff.prdata;
   assign pready       = st_ff.pready;
   assign pslverr      = st_ff.pslverr;
   assign ss_issue     = st_ff.ss_go;
   assign cs_issue     = st_ff.cs_go;
   assign issue_uframe = st_ff.go_uframe;
   assign irq          = st_ff.irq;

endmodule
